//--- src/msp_defines.svh
/*
 * constants of the major-state sequencer and memory guard
 * assumes: included by bare name, after the package
 */
`ifndef MSP_DEFINES_SVH
`define MSP_DEFINES_SVH

// ----------------------------------------
// instruction word fields
// ----------------------------------------
`define MSP_OP_HI 11
`define MSP_OP_LO 9
`define MSP_INDIRECT_BIT 8
`define MSP_OP_AND 3'h0
`define MSP_OP_ADD 3'h1
`define MSP_OP_INC_SKIP 3'h2
`define MSP_OP_STORE_CLEAR 3'h3
`define MSP_OP_SUB_CALL 3'h4
`define MSP_OP_JUMP 3'h5
`define MSP_OP_IO_XFER 3'h6
`define MSP_OP_OPERATE 3'h7

// ----------------------------------------
// guarded window, octal 7600 to 7777
// ----------------------------------------
`define MSP_GUARD_LO 12'hF80
`define MSP_GUARD_HI 12'hFFF
`define MSP_GUARD_MSB 11
`define MSP_GUARD_LSB 7

// ----------------------------------------
// timing
// ----------------------------------------
`define MSP_CLK_NS 8
`define MSP_CYCLE_NS 1600
`define MSP_CYCLE_CLKS (`MSP_CYCLE_NS / `MSP_CLK_NS)

`endif

//--- src/msp_pkg.sv
/*
 * types of the major-state sequencer and memory guard
 * assumes: compiled before the module
 */
package msp_pkg;

	// ----------------------------------------
	// major states, index into the one-hot word
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		MSP_FETCH,
		MSP_DEFER,
		MSP_EXEC,
		MSP_COUNT,
		MSP_ADDR,
		MSP_BREAK
	} msp_state_t;

	// ----------------------------------------
	// processor timing levels and pulses
	// ----------------------------------------
	typedef struct packed
	{
		logic time_pulse_one;
		logic time_pulse_two;
		logic time_pulse_three;
		logic time_pulse_four;
		logic time_state_two;
		logic manual_pulse_two;
	} msp_timing_t;

	// ----------------------------------------
	// data-path gate permissions
	// ----------------------------------------
	typedef struct packed
	{
		logic sense_gate_hi;
		logic sense_gate_lo;
		logic sum_register_gate;
		logic switch_register_gate;
		logic carry_insert;
		logic program_counter_load;
	} msp_gate_t;

endpackage

//--- src/msp_major_state.sv
/*
 * major-state sequencer of a 12-bit processor with a guard on
 * the top 128 words of memory, and a two-entry buffer for
 * incoming data-break words.
 * assumes: time pulses are one-cycle enables from the timing
 * generator; all inputs are synchronous to clk_i.
 */
// Summary of operation
// - with protect key on, octal 7600-7777 in top field is guarded in time state two only; break words drain outside it
// - protect in time state two: key, field enable, address top, alter
// - write alter on store, subroutine call, break data in, store switch
// - increment alter on skip carry, break increments, look or store keys
// - word count state raises protect at start of a 3-cycle break
// - protect sets bad reference at pulse two; run clears at pulse three
// - protect suppresses sense, sum, switch, carry and counter load gates
// - six major states, each one full 1.6 us cycle
// - fetch reads instruction, keeps opcode, increments program counter
// - manual pulse two with go switch sets fetch
// - fetch next only without defer, execute, break or extra cycle
// - defer next from fetch on indirect non io, non operate
// - defer goes to execute except jump; jump returns to fetch
// - execute next from fetch on direct multi-cycle non jump
// - granted program break enters execute after fetch/defer/exec/break
// - execute reads operand, stores sum register, or calls subroutine
// - peripheral marks 3-cycle; count state entered at pulse four
// - count state increments count, flags overflow, then address state
// - address state increments unless inhibited, then break state
// - data-in break moves buffered words via buffer when not guarded, program state untouched
// - break request synchronised at pulse one for both kinds
// - after break: count if 3-cycle, execute if program break, fetch
`timescale 1ns/1ns
`include "msp_defines.svh"

module msp_major_state
#(
	parameter int W = 12,
	parameter int DEPTH = 2
)
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// timing
	input wire msp_pkg::msp_timing_t timing_i,
	// front panel
	input wire logic go_switch_i,
	input wire logic protect_switch_i,
	input wire logic store_switch_i,
	input wire logic look_switch_i,
	input wire logic single_step_i,
	input wire logic ext_field_enable_i,
	// processor
	input wire logic [11:0] memory_buffer_i,
	input wire logic [11:0] memory_address_i,
	input wire logic extra_cycle_i,
	input wire logic interrupt_grant_i,
	input wire logic count_carry_i,
	// peripheral break control
	input wire logic break_request_i,
	input wire logic three_cycle_i,
	input wire logic increment_inhibit_i,
	input wire logic memory_increment_i,
	input wire logic data_in_i,
	output logic count_overflow_o,
	// break data stream
	input wire logic [W-1:0] brk_data_i,
	input wire logic brk_valid_i,
	output logic brk_ready_o,
	output logic [W-1:0] mem_data_o,
	output logic mem_valid_o,
	input wire logic mem_ready_i,
	// status and gates
	output logic [5:0] state_o,
	output logic [2:0] opcode_o,
	output logic pc_increment_o,
	output logic protect_o,
	output logic bad_reference_flag_o,
	output logic run_clear_o,
	output msp_pkg::msp_gate_t gate_o
);
	import msp_pkg::*;

	function automatic logic op_is(input logic [11:0] word,
		input logic [2:0] op);
		op_is = (word[`MSP_OP_HI:`MSP_OP_LO] == op);
	endfunction

	// ----------------------------------------
	// instruction decode
	// ----------------------------------------
	logic [5:0] state_q, state_d;
	logic st_fetch, st_defer, st_exec, st_count, st_addr, st_break;
	logic indirect, is_jump, io_or_op, multi;
	logic op_store, op_call, op_skip;

	assign st_fetch = state_q[MSP_FETCH];
	assign st_defer = state_q[MSP_DEFER];
	assign st_exec = state_q[MSP_EXEC];
	assign st_count = state_q[MSP_COUNT];
	assign st_addr = state_q[MSP_ADDR];
	assign st_break = state_q[MSP_BREAK];

	assign indirect = memory_buffer_i[`MSP_INDIRECT_BIT];
	assign is_jump = op_is(memory_buffer_i, `MSP_OP_JUMP);
	assign io_or_op = op_is(memory_buffer_i, `MSP_OP_IO_XFER)
		| op_is(memory_buffer_i, `MSP_OP_OPERATE);
	assign multi = ~io_or_op;
	// execute-state operation comes from the held opcode
	assign op_store = (opcode_o == `MSP_OP_STORE_CLEAR);
	assign op_call = (opcode_o == `MSP_OP_SUB_CALL);
	assign op_skip = (opcode_o == `MSP_OP_INC_SKIP);

	// ----------------------------------------
	// break synchroniser
	// ----------------------------------------
	logic brk_sync_q, brk_sync_d, three_q, three_d;

	always_comb
	begin
		brk_sync_d = brk_sync_q;
		three_d = three_q;
		if (timing_i.time_pulse_one)
		begin
			brk_sync_d = break_request_i;
			three_d = three_cycle_i;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			brk_sync_q <= 1'b0;
			three_q <= 1'b0;
		end
		else
		begin
			brk_sync_q <= brk_sync_d;
			three_q <= three_d;
		end
	end

	// ----------------------------------------
	// next major state
	// ----------------------------------------
	logic defer_next, exec_instr, instr_done, break_ok, fetch_next;
	logic count_next, go_pulse;

	assign go_pulse = timing_i.manual_pulse_two & go_switch_i;
	assign defer_next = st_fetch & indirect & multi;
	assign exec_instr = (st_fetch & ~indirect & multi & ~is_jump)
		| (st_defer & ~(opcode_o == `MSP_OP_JUMP));
	assign instr_done = ~defer_next & ~exec_instr & ~extra_cycle_i;
	assign break_ok = brk_sync_q & instr_done & ~st_count & ~st_addr;
	assign count_next = break_ok & three_q;
	assign fetch_next = instr_done & ~break_ok & ~interrupt_grant_i;

	always_comb
	begin
		state_d = state_q;
		if (go_pulse)
		begin
			state_d = '0;
			state_d[MSP_FETCH] = 1'b1;
		end
		else if (timing_i.time_pulse_four)
		begin
			state_d = '0;
			if (st_count)
				state_d[MSP_ADDR] = 1'b1;
			else if (st_addr)
				state_d[MSP_BREAK] = 1'b1;
			else if (defer_next)
				state_d[MSP_DEFER] = 1'b1;
			else if (exec_instr)
				state_d[MSP_EXEC] = 1'b1;
			else if (count_next)
				state_d[MSP_COUNT] = 1'b1;
			else if (break_ok)
				state_d[MSP_BREAK] = 1'b1;
			else if (interrupt_grant_i)
				state_d[MSP_EXEC] = 1'b1;
			else if (fetch_next)
				state_d[MSP_FETCH] = 1'b1;
			else
				state_d = state_q; // extra cycle holds the state
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state_q <= 6'h01;
		else
			state_q <= state_d;
	end

	assign state_o = state_q;

	// ----------------------------------------
	// memory guard
	// ----------------------------------------
	logic write_alter_level, increment_alter_level, guard_top, carry_req;

	assign write_alter_level = (st_exec & (op_store | op_call))
		| (st_break & data_in_i) | store_switch_i;
	assign carry_req = (st_exec & op_skip)
		| (st_addr & ~increment_inhibit_i)
		| ((st_break | st_count) & memory_increment_i);
	assign increment_alter_level = carry_req | look_switch_i
		| store_switch_i;
	assign guard_top =
		&memory_address_i[`MSP_GUARD_MSB:`MSP_GUARD_LSB];
	assign protect_o = timing_i.time_state_two & protect_switch_i
		& ext_field_enable_i & guard_top
		& (write_alter_level | increment_alter_level | st_count);

	always_comb
	begin
		gate_o.sense_gate_hi = ~protect_o;
		gate_o.sense_gate_lo = ~protect_o;
		gate_o.sum_register_gate = st_exec & op_store & ~protect_o;
		gate_o.switch_register_gate = store_switch_i & ~protect_o;
		gate_o.carry_insert = carry_req & ~protect_o;
		gate_o.program_counter_load = st_exec & op_call & ~protect_o;
	end

	// ----------------------------------------
	// flags, opcode and pulses
	// ----------------------------------------
	logic bad_ref_d, run_clear_d, overflow_d, pc_inc_d;
	logic [2:0] opcode_d;

	always_comb
	begin
		bad_ref_d = bad_reference_flag_o;
		opcode_d = opcode_o;
		if (go_pulse)
			bad_ref_d = 1'b0;
		if (protect_o & timing_i.time_pulse_two)
			bad_ref_d = 1'b1;
		if (st_fetch & timing_i.time_pulse_two)
			opcode_d = memory_buffer_i[`MSP_OP_HI:`MSP_OP_LO];
		run_clear_d = timing_i.time_pulse_three
			& (bad_reference_flag_o | single_step_i);
		overflow_d = st_count & count_carry_i & timing_i.time_pulse_three;
		pc_inc_d = st_fetch & timing_i.time_pulse_three;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bad_reference_flag_o <= 1'b0;
			opcode_o <= 3'h0;
			run_clear_o <= 1'b0;
			count_overflow_o <= 1'b0;
			pc_increment_o <= 1'b0;
		end
		else
		begin
			bad_reference_flag_o <= bad_ref_d;
			opcode_o <= opcode_d;
			run_clear_o <= run_clear_d;
			count_overflow_o <= overflow_d;
			pc_increment_o <= pc_inc_d;
		end
	end

	// ----------------------------------------
	// break data buffer
	// ----------------------------------------
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] buf_q [DEPTH];
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [PW:0] cnt_q, cnt_d;
	logic push, pop;

	assign brk_ready_o = (cnt_q != DEPTH[PW:0]);
	// words leave only in a break state that is not guarded
	assign mem_valid_o = (cnt_q != '0) & st_break & data_in_i
		& ~protect_o;
	assign mem_data_o = buf_q[rd_q];
	assign push = brk_valid_i & brk_ready_o;
	assign pop = mem_valid_o & mem_ready_i;

	always_comb
	begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push)
			wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		if (pop)
			rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		if (push & ~pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop & ~push)
			cnt_d = cnt_q - 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
		if (push)
			buf_q[wr_q] <= brk_data_i;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence count_tick;
		st_count && timing_i.time_pulse_four && !go_pulse;
	endsequence

	sequence addr_tick;
		st_addr && timing_i.time_pulse_four && !go_pulse;
	endsequence

	state_onehot_a: assert property ($onehot(state_q))
		else $error("major state not one-hot");

	state_hold_a: assert property
		(!timing_i.time_pulse_four && !go_pulse |=> $stable(state_q))
		else $error("major state moved off pulse four");

	fetch_start_a: assert property (go_pulse |=> st_fetch)
		else $error("go pulse did not set fetch");

	defer_select_a: assert property
		(defer_next && timing_i.time_pulse_four && !go_pulse
		|=> st_defer)
		else $error("indirect instruction skipped defer");

	exec_select_a: assert property
		(st_fetch && !indirect && multi && !is_jump
		&& timing_i.time_pulse_four && !go_pulse |=> st_exec)
		else $error("direct instruction skipped execute");

	three_walk_a: assert property (addr_tick |=> st_break)
		else $error("three-cycle break walk broken");

	count_addr_a: assert property (count_tick |=> st_addr)
		else $error("count state not followed by address");

	sync_catch_a: assert property
		(timing_i.time_pulse_one && break_request_i |=> brk_sync_q)
		else $error("break request not synchronised");

	bad_ref_a: assert property
		(protect_o && timing_i.time_pulse_two && !go_pulse
		|=> bad_reference_flag_o)
		else $error("guard hit did not set bad reference");

	run_clear_a: assert property
		(bad_reference_flag_o && timing_i.time_pulse_three
		|=> run_clear_o)
		else $error("run not cleared after bad reference");

	guard_gates_a: assert property
		(protect_o |-> !gate_o.sense_gate_hi && !gate_o.sense_gate_lo
		&& !gate_o.carry_insert && !gate_o.program_counter_load
		&& !gate_o.sum_register_gate && !gate_o.switch_register_gate)
		else $error("gate open while guarded");

	guard_window_a: assert property
		(protect_o |-> memory_address_i >= `MSP_GUARD_LO
		&& memory_address_i <= `MSP_GUARD_HI)
		else $error("guard outside top window");

	no_write_a: assert property (protect_o |-> !pop)
		else $error("break word written while guarded");

endmodule

//--- verification/msp_periph_model.sv
/*
 * data-break peripheral and core-memory sink for the sequencer
 * assumes: commands from the bench change just after a clock edge
 */
`timescale 1ns/1ns

module msp_periph_model
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench commands
	input wire logic want_brk_i,
	input wire logic want_three_i,
	input wire logic want_in_i,
	input wire logic send_i,
	input wire logic stall_i,
	// break control
	output logic break_request_o,
	output logic three_cycle_o,
	output logic increment_inhibit_o,
	output logic data_in_o,
	// word stream
	output logic [11:0] brk_data_o,
	output logic brk_valid_o,
	input wire logic brk_ready_i,
	input wire logic [11:0] mem_data_i,
	input wire logic mem_valid_i,
	output logic mem_ready_o,
	// progress
	output logic [1:0] sent_o,
	output logic [1:0] got_o,
	output logic [11:0] last_o
);
	assign break_request_o = want_brk_i;
	assign three_cycle_o = want_brk_i & want_three_i;
	assign increment_inhibit_o = 1'b0;
	assign data_in_o = want_in_i;
	assign mem_ready_o = !stall_i;

	// two words per send; a released data line shows the inverse
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			brk_valid_o <= 1'b0;
			brk_data_o <= 12'h000;
			sent_o <= 2'h0;
			got_o <= 2'h0;
			last_o <= 12'h000;
		end
		else
		begin
			if (send_i)
			begin
				brk_valid_o <= 1'b1;
				brk_data_o <= 12'hA5C;
				sent_o <= 2'h0;
			end
			else if (brk_valid_o && brk_ready_i)
			begin
				sent_o <= sent_o + 2'h1;
				brk_data_o <= (sent_o == 2'h0) ? 12'h5A3 : ~brk_data_o;
				brk_valid_o <= (sent_o == 2'h0);
			end
			if (mem_valid_i && mem_ready_o)
			begin
				got_o <= got_o + 2'h1;
				last_o <= mem_data_i;
			end
		end
	end
endmodule

//--- verification/tb.sv
/*
 * self-checking bench of the major-state sequencer and guard
 * assumes: msp_pkg and msp_periph_model are compiled first
 */
`timescale 1ns/1ns

module tb;
	import msp_pkg::*;
	logic clk_i, rst_i, go_switch_i, protect_switch_i, store_switch_i;
	logic look_switch_i, single_step_i, ext_field_enable_i;
	logic extra_cycle_i, interrupt_grant_i, count_carry_i;
	logic memory_increment_i, mem_ready_i, brk_valid_i, brk_ready_o;
	logic break_request_i, three_cycle_i, increment_inhibit_i, data_in_i;
	logic count_overflow_o, mem_valid_o, pc_increment_o, protect_o;
	logic bad_reference_flag_o, run_clear_o, pc_seen, ov_seen;
	logic want_brk, want_three, want_in, send, stall;
	logic [11:0] memory_buffer_i, memory_address_i, brk_data_i;
	logic [11:0] mem_data_o, last;
	logic [5:0] state_o;
	logic [2:0] opcode_o;
	logic [1:0] sent, got;
	msp_timing_t timing_i;
	msp_gate_t gate_o;
	int fail_count, tests_run;

	msp_major_state DUT (.clk_i, .rst_i, .timing_i, .go_switch_i,
		.protect_switch_i, .store_switch_i, .look_switch_i,
		.single_step_i, .ext_field_enable_i, .memory_buffer_i,
		.memory_address_i, .extra_cycle_i, .interrupt_grant_i,
		.count_carry_i, .break_request_i, .three_cycle_i,
		.increment_inhibit_i, .memory_increment_i, .data_in_i,
		.count_overflow_o, .brk_data_i, .brk_valid_i, .brk_ready_o,
		.mem_data_o, .mem_valid_o, .mem_ready_i, .state_o, .opcode_o,
		.pc_increment_o, .protect_o, .bad_reference_flag_o,
		.run_clear_o, .gate_o);

	msp_periph_model peer (.clk_i(clk_i), .rst_i(rst_i),
		.want_brk_i(want_brk), .want_three_i(want_three),
		.want_in_i(want_in), .send_i(send), .stall_i(stall),
		.break_request_o(break_request_i), .three_cycle_o(three_cycle_i),
		.increment_inhibit_o(increment_inhibit_i),
		.data_in_o(data_in_i), .brk_data_o(brk_data_i),
		.brk_valid_o(brk_valid_i), .brk_ready_i(brk_ready_o),
		.mem_data_i(mem_data_o), .mem_valid_i(mem_valid_o),
		.mem_ready_o(mem_ready_i), .sent_o(sent), .got_o(got),
		.last_o(last));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task report_and_stop;
		$display("mismatches %0d of %0d checks", fail_count, tests_run);
		if (fail_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		tests_run++;
		if (g !== e)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one memory cycle; pulse two falls inside time state two
	task mcycle;
		@(posedge clk_i);
		timing_i.time_pulse_one <= 1'b1;
		timing_i.time_state_two <= 1'b1;
		@(posedge clk_i);
		timing_i.time_pulse_one <= 1'b0;
		timing_i.time_pulse_two <= 1'b1;
		@(posedge clk_i);
		timing_i.time_pulse_two <= 1'b0;
		timing_i.time_state_two <= 1'b0;
		timing_i.time_pulse_three <= 1'b1;
		@(posedge clk_i);
		timing_i.time_pulse_three <= 1'b0;
		timing_i.time_pulse_four <= 1'b1;
		#1;
		pc_seen = pc_increment_o;
		ov_seen = count_overflow_o;
		@(posedge clk_i);
		timing_i.time_pulse_four <= 1'b0;
		#1;
	endtask

	task step(input logic [11:0] w, input logic [5:0] e);
		@(posedge clk_i);
		memory_buffer_i <= w;
		mcycle;
		chk("state", 12'(e), 12'(state_o));
	endtask

	task go_pulse;
		@(posedge clk_i);
		timing_i.manual_pulse_two <= 1'b1;
		go_switch_i <= 1'b1;
		@(posedge clk_i);
		timing_i.manual_pulse_two <= 1'b0;
		go_switch_i <= 1'b0;
		#1;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		chk("state", 12'h001, 12'(state_o));
		chk("fill_ready", 12'h001, 12'(brk_ready_o));
		chk("drain_valid", 12'h000, 12'(mem_valid_o));
	endtask

	task t_instr;
		go_pulse;
		chk("state", 12'h001, 12'(state_o));
		step(12'hE00, 6'h01);
		chk("pc_inc", 12'h001, 12'(pc_seen));
		chk("opcode", 12'h007, 12'(opcode_o));
		step(12'h200, 6'h04);
		step(12'h200, 6'h01);
		chk("pc_inc", 12'h000, 12'(pc_seen));
		step(12'h300, 6'h02);
		step(12'h300, 6'h04);
		step(12'h300, 6'h01);
		step(12'h600, 6'h04);
		chk("sum_gate", 12'h001, 12'(gate_o.sum_register_gate));
		step(12'h600, 6'h01);
		step(12'h800, 6'h04);
		chk("program_counter_load", 12'h001, 12'(gate_o.program_counter_load));
		step(12'h800, 6'h01);
		step(12'hB00, 6'h02);
		step(12'hB00, 6'h01);
		step(12'hA00, 6'h01);
		step(12'hD00, 6'h01);
	endtask

	task t_break3;
		@(posedge clk_i);
		want_brk <= 1'b1;
		want_three <= 1'b1;
		count_carry_i <= 1'b1;
		step(12'hE00, 6'h08);
		step(12'hE00, 6'h10);
		chk("overflow", 12'h001, 12'(ov_seen));
		chk("carry_gate", 12'h001, 12'(gate_o.carry_insert));
		step(12'hE00, 6'h20);
		step(12'hE00, 6'h08);
		step(12'hE00, 6'h10);
		@(posedge clk_i);
		want_brk <= 1'b0;
		want_three <= 1'b0;
		count_carry_i <= 1'b0;
		step(12'hE00, 6'h20);
		step(12'hE00, 6'h01);
	endtask

	task t_break1;
		@(posedge clk_i);
		want_brk <= 1'b1;
		extra_cycle_i <= 1'b1;
		step(12'hE00, 6'h01);
		@(posedge clk_i);
		extra_cycle_i <= 1'b0;
		step(12'hE00, 6'h20);
		@(posedge clk_i);
		want_brk <= 1'b0;
		interrupt_grant_i <= 1'b1;
		step(12'hE00, 6'h04);
		@(posedge clk_i);
		interrupt_grant_i <= 1'b0;
		step(12'hE00, 6'h01);
	endtask

	task t_buffer;
		int i;
		@(posedge clk_i);
		want_brk <= 1'b1;
		want_in <= 1'b1;
		stall <= 1'b1;
		step(12'hE00, 6'h20);
		@(posedge clk_i);
		send <= 1'b1;
		@(posedge clk_i);
		send <= 1'b0;
		for (i = 0; i < 20 && sent != 2'h2; i++)
			@(posedge clk_i);
		#1;
		chk("fill_ready", 12'h000, 12'(brk_ready_o));
		chk("drain_data", 12'hA5C, mem_data_o);
		@(posedge clk_i);
		stall <= 1'b0;
		for (i = 0; i < 20 && got != 2'h2; i++)
			@(posedge clk_i);
		#1;
		chk("last_word", 12'h5A3, last);
		chk("drain_valid", 12'h000, 12'(mem_valid_o));
		@(posedge clk_i);
		want_brk <= 1'b0;
		want_in <= 1'b0;
		step(12'hE00, 6'h01);
	endtask

	task t_protect;
		@(posedge clk_i);
		protect_switch_i <= 1'b1;
		ext_field_enable_i <= 1'b1;
		store_switch_i <= 1'b1;
		memory_address_i <= 12'hF80;
		timing_i.time_state_two <= 1'b1;
		@(posedge clk_i);
		#1;
		chk("protect", 12'h001, 12'(protect_o));
		chk("gates", 12'h000, 12'({gate_o.sense_gate_hi,
			gate_o.sense_gate_lo, gate_o.switch_register_gate,
			gate_o.carry_insert}));
		@(posedge clk_i);
		memory_address_i <= 12'hF7F;
		@(posedge clk_i);
		#1;
		chk("protect", 12'h000, 12'(protect_o));
		chk("switch_gate", 12'h001, 12'(gate_o.switch_register_gate));
		@(posedge clk_i);
		memory_address_i <= 12'hFFF;
		timing_i.time_pulse_two <= 1'b1;
		@(posedge clk_i);
		timing_i.time_pulse_two <= 1'b0;
		timing_i.time_state_two <= 1'b0;
		#1;
		chk("bad_ref", 12'h001, 12'(bad_reference_flag_o));
		@(posedge clk_i);
		timing_i.time_pulse_three <= 1'b1;
		@(posedge clk_i);
		timing_i.time_pulse_three <= 1'b0;
		protect_switch_i <= 1'b0;
		store_switch_i <= 1'b0;
		#1;
		chk("run_clear", 12'h001, 12'(run_clear_o));
		go_pulse;
		chk("bad_ref", 12'h000, 12'(bad_reference_flag_o));
		@(posedge clk_i);
		single_step_i <= 1'b1;
		timing_i.time_pulse_three <= 1'b1;
		@(posedge clk_i);
		timing_i.time_pulse_three <= 1'b0;
		single_step_i <= 1'b0;
		#1;
		chk("run_clear", 12'h001, 12'(run_clear_o));
	endtask

	// ----------------------------------------
	// clock, watchdog, main sequence
	// ----------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever
			#4 clk_i = ~clk_i;
	end

	initial
	begin
		#200000;
		fail_count++;
		report_and_stop;
	end

	initial
	begin
		rst_i = 1'b1;
		timing_i = '0;
		{go_switch_i, protect_switch_i, store_switch_i} = 3'h0;
		{look_switch_i, single_step_i, ext_field_enable_i} = 3'h0;
		{extra_cycle_i, interrupt_grant_i, count_carry_i} = 3'h0;
		{memory_increment_i, want_brk, want_three, want_in} = 4'h0;
		{send, stall} = 2'h0;
		memory_buffer_i = 12'hE00;
		memory_address_i = 12'h000;
		fail_count = 0;
		tests_run = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		t_reset;
		t_instr;
		t_break3;
		t_break1;
		t_buffer;
		t_protect;
		report_and_stop;
	end
endmodule
